// *** core/cafpc_pkg.sv ***
// Purpose: Constants for the acceptance filter pair control block
// Assumes: 32-bit APB, one register word per offset
// Notes:   Offsets are byte addresses
package cafpc_pkg;
	localparam logic [11:0] CAFPC_ADDR_CTRL7  = 12'h000;
	localparam logic [11:0] CAFPC_ADDR_STATUS = 12'h004;
	localparam logic [11:0] CAFPC_ADDR_MATCH  = 12'h008;
	localparam logic [31:0] CAFPC_CTRL_RESET  = 32'h0000_0000;
	localparam int          CAFPC_F29_EN      = 15;
	localparam int          CAFPC_F29_MSK_HI  = 14;
	localparam int          CAFPC_F29_MSK_LO  = 13;
	localparam int          CAFPC_F29_FIFO_HI = 12;
	localparam int          CAFPC_F29_FIFO_LO = 8;
	localparam int          CAFPC_F28_EN      = 7;
	localparam int          CAFPC_F28_MSK_HI  = 6;
	localparam int          CAFPC_F28_MSK_LO  = 5;
	localparam int          CAFPC_F28_FIFO_HI = 4;
	localparam int          CAFPC_F28_FIFO_LO = 0;
	localparam int          CAFPC_MASKS       = 4;
	localparam int          CAFPC_ID_W        = 29;
endpackage

// *** core/cafpc_match.sv ***
// Purpose: One filter compare: masked identifier match gated by enable
// Assumes: Mask and filter values come from the surrounding module
// Notes:   Purely combinational, registered by the caller
`timescale 1ns/1ps
`default_nettype none
module cafpc_match
	import cafpc_pkg::*;
(
	// Filter settings
	input  wire logic                  enable,
	input  wire logic [1:0]            mask_select,
	input  wire logic [CAFPC_ID_W-1:0] filter_id,
	// Mask bank
	input  wire logic [CAFPC_ID_W-1:0] mask0,
	input  wire logic [CAFPC_ID_W-1:0] mask1,
	input  wire logic [CAFPC_ID_W-1:0] mask2,
	input  wire logic [CAFPC_ID_W-1:0] mask3,
	// Message
	input  wire logic [CAFPC_ID_W-1:0] msg_id,
	output logic                       hit
);
	logic [CAFPC_ID_W-1:0] mask;
	always_comb begin
		case (mask_select)
			2'h0: mask = mask0;
			2'h1: mask = mask1;
			2'h2: mask = mask2;
			2'h3: mask = mask3;
			default: mask = mask0;
		endcase
		hit = enable && (((msg_id ^ filter_id) & mask) == '0);
	end
endmodule
`default_nettype wire

// *** core/cafpc_top.sv ***
// Purpose: Control word and routing for acceptance filters 28 and 29
// Assumes: APB slave, masks and filter ids supplied by the CAN core
// Notes:   Routing result is registered; one cycle after msg_valid
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Bit 15 of the control word enables filter 29 when 1 and disables it when 0.
// - Bits 14 to 13 pick acceptance mask 0 to 3 for filter 29.
// - A message matching filter 29 goes to the FIFO numbered by bits 12 to 8.
// - Bit 7 of the control word enables filter 28 when 1 and disables it when 0.
// - Bits 6 to 5 pick acceptance mask 0 to 3 for filter 28.
// - A message matching filter 28 goes to the FIFO numbered by bits 4 to 0; the code uses bits 12 to 8 when filter 29 also matches.
// - Mask and FIFO selects of a filter change only while its enable bit is 0.
module cafpc_top
	import cafpc_pkg::*;
(
	// Clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Filter comparison inputs
	input  wire logic [CAFPC_ID_W-1:0] mask0,
	input  wire logic [CAFPC_ID_W-1:0] mask1,
	input  wire logic [CAFPC_ID_W-1:0] mask2,
	input  wire logic [CAFPC_ID_W-1:0] mask3,
	input  wire logic [CAFPC_ID_W-1:0] filter28_id,
	input  wire logic [CAFPC_ID_W-1:0] filter29_id,
	// Received message
	input  wire logic                  msg_valid,
	input  wire logic [CAFPC_ID_W-1:0] msg_id,
	// Routing result
	output logic                       route_valid,
	output logic [4:0]                 route_fifo,
	output logic                       route_filter29,
	// Settings to the CAN core
	output logic                       filter29_enable,
	output logic [1:0]                 filter29_mask_select,
	output logic [4:0]                 filter29_fifo_select,
	output logic                       filter28_enable,
	output logic [1:0]                 filter28_mask_select,
	output logic [4:0]                 filter28_fifo_select
);
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] rdata;
		logic        ready;
		logic        err;
		logic        rvalid;
		logic [4:0]  rfifo;
		logic        rf29;
		logic [7:0]  hits28;
		logic [7:0]  hits29;
	} cafpc_state_t;

	cafpc_state_t s_q;
	cafpc_state_t s_d;
	logic         hit28;
	logic         hit29;

	// Merge written bytes with the old word
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] strb);
		logic [31:0] r;
		r = old_w;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = new_w[8*i +: 8];
			end
		end
		return r;
	endfunction

	cafpc_match u_f28 (
		.enable      (s_q.ctrl[CAFPC_F28_EN]),
		.mask_select (s_q.ctrl[CAFPC_F28_MSK_HI:CAFPC_F28_MSK_LO]),
		.filter_id   (filter28_id),
		.mask0       (mask0),
		.mask1       (mask1),
		.mask2       (mask2),
		.mask3       (mask3),
		.msg_id      (msg_id),
		.hit         (hit28)
	);

	cafpc_match u_f29 (
		.enable      (s_q.ctrl[CAFPC_F29_EN]),
		.mask_select (s_q.ctrl[CAFPC_F29_MSK_HI:CAFPC_F29_MSK_LO]),
		.filter_id   (filter29_id),
		.mask0       (mask0),
		.mask1       (mask1),
		.mask2       (mask2),
		.mask3       (mask3),
		.msg_id      (msg_id),
		.hit         (hit29)
	);

	always_comb begin
		logic [31:0] wr;
		logic        setup;
		wr = '0;
		setup = psel && !penable;
		s_d = s_q;
		s_d.ready = setup;
		s_d.err = 1'b0;
		// Write takes effect in setup, so the answer comes in the first access cycle, with no wait state
		if (setup && pwrite) begin
			case (paddr)
				CAFPC_ADDR_CTRL7: begin
					wr = merge_bytes(s_q.ctrl, pwdata, pstrb);
					s_d.ctrl[CAFPC_F29_EN] = wr[CAFPC_F29_EN];
					s_d.ctrl[CAFPC_F28_EN] = wr[CAFPC_F28_EN];
					// Locked while enabled so routing never sees a half-changed filter
					if (!s_q.ctrl[CAFPC_F29_EN]) begin
						s_d.ctrl[CAFPC_F29_MSK_HI:CAFPC_F29_FIFO_LO] =
							wr[CAFPC_F29_MSK_HI:CAFPC_F29_FIFO_LO];
					end
					if (!s_q.ctrl[CAFPC_F28_EN]) begin
						s_d.ctrl[CAFPC_F28_MSK_HI:CAFPC_F28_FIFO_LO] =
							wr[CAFPC_F28_MSK_HI:CAFPC_F28_FIFO_LO];
					end
				end
				CAFPC_ADDR_STATUS: begin
				end
				CAFPC_ADDR_MATCH: begin
					s_d.hits28 = 8'h00;
					s_d.hits29 = 8'h00;
				end
				default: s_d.err = 1'b1;
			endcase
		end else if (setup) begin
			case (paddr)
				CAFPC_ADDR_CTRL7: s_d.rdata = s_q.ctrl;
				CAFPC_ADDR_STATUS: s_d.rdata = {25'h0000000, s_q.rf29, s_q.rfifo, s_q.rvalid};
				CAFPC_ADDR_MATCH: s_d.rdata = {16'h0000, s_q.hits29, s_q.hits28};
				default: begin
					s_d.rdata = 32'h0000_0000;
					s_d.err = 1'b1;
				end
			endcase
		end
		// Filter 29 wins when both hit; counters saturate
		s_d.rvalid = 1'b0;
		if (msg_valid && (hit29 || hit28)) begin
			s_d.rvalid = 1'b1;
			s_d.rf29 = hit29;
			if (hit29) begin
				s_d.rfifo = s_q.ctrl[CAFPC_F29_FIFO_HI:CAFPC_F29_FIFO_LO];
			end else begin
				s_d.rfifo = s_q.ctrl[CAFPC_F28_FIFO_HI:CAFPC_F28_FIFO_LO];
			end
			if (hit29 && s_q.hits29 != 8'hFF) begin
				s_d.hits29 = s_q.hits29 + 8'h01;
			end
			if (hit28 && s_q.hits28 != 8'hFF) begin
				s_d.hits28 = s_q.hits28 + 8'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.ctrl <= CAFPC_CTRL_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.rdata;
	assign pready = s_q.ready;
	assign pslverr = s_q.err;
	assign route_valid = s_q.rvalid;
	assign route_fifo = s_q.rfifo;
	assign route_filter29 = s_q.rf29;
	assign filter29_enable = s_q.ctrl[CAFPC_F29_EN];
	assign filter29_mask_select = s_q.ctrl[CAFPC_F29_MSK_HI:CAFPC_F29_MSK_LO];
	assign filter29_fifo_select = s_q.ctrl[CAFPC_F29_FIFO_HI:CAFPC_F29_FIFO_LO];
	assign filter28_enable = s_q.ctrl[CAFPC_F28_EN];
	assign filter28_mask_select = s_q.ctrl[CAFPC_F28_MSK_HI:CAFPC_F28_MSK_LO];
	assign filter28_fifo_select = s_q.ctrl[CAFPC_F28_FIFO_HI:CAFPC_F28_FIFO_LO];
endmodule
`default_nettype wire

// *** sim/cafpc_asserts.sv ***
// Purpose: Checker for control word and routing ports
// Assumes: Single clock, async active-low reset
// Notes:   Bound to every cafpc_top instance
`timescale 1ns/1ps
`default_nettype none
module cafpc_asserts (
	// Clock, reset and APB
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	// Routing and settings
	input wire logic        msg_valid,
	input wire logic        route_valid,
	input wire logic [4:0]  route_fifo,
	input wire logic        route_filter29,
	input wire logic        filter29_enable,
	input wire logic [1:0]  filter29_mask_select,
	input wire logic [4:0]  filter29_fifo_select,
	input wire logic        filter28_enable,
	input wire logic [1:0]  filter28_mask_select,
	input wire logic [4:0]  filter28_fifo_select
);
	logic wr;
	assign wr = psel && !penable && pwrite && paddr == 12'h000;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	en29_a: assert property (wr && pstrb[1] |=> filter29_enable == $past(pwdata[15]))
		else $error("filter 29 enable not written");
	en28_a: assert property (wr && pstrb[0] |=> filter28_enable == $past(pwdata[7]))
		else $error("filter 28 enable not written");
	sel29_a: assert property (wr && pstrb[1] && !filter29_enable
		|=> {filter29_mask_select, filter29_fifo_select} == $past(pwdata[14:8]))
		else $error("filter 29 selects not written");
	sel28_a: assert property (wr && pstrb[0] && !filter28_enable
		|=> {filter28_mask_select, filter28_fifo_select} == $past(pwdata[6:0]))
		else $error("filter 28 selects not written");
	lock29_a: assert property (filter29_enable
		|=> $stable({filter29_mask_select, filter29_fifo_select}))
		else $error("filter 29 selects changed while enabled");
	lock28_a: assert property (filter28_enable
		|=> $stable({filter28_mask_select, filter28_fifo_select}))
		else $error("filter 28 selects changed while enabled");
	off_route_a: assert property (msg_valid && !filter29_enable && !filter28_enable
		|=> !route_valid) else $error("route with both filters off");
	route_fifo_a: assert property (route_valid |-> route_fifo == (route_filter29
		? $past(filter29_fifo_select) : $past(filter28_fifo_select)))
		else $error("route to wrong fifo");
endmodule
bind cafpc_top cafpc_asserts cafpc_asserts_i (.*);
`default_nettype wire

// *** sim/cafpc_msg_model.sv ***
// Purpose: Receive side model: masks, filter values, messages
// Assumes: One message per send call
// Notes:   Released id is inverted so it never looks valid
`timescale 1ns/1ps
`default_nettype none
module cafpc_msg_model
	import cafpc_pkg::*;
(
	// Clock
	input  wire logic                  pclk,
	// Masks, filter values and message
	output logic [CAFPC_ID_W-1:0]      mask0,
	output logic [CAFPC_ID_W-1:0]      mask1,
	output logic [CAFPC_ID_W-1:0]      mask2,
	output logic [CAFPC_ID_W-1:0]      mask3,
	output logic [CAFPC_ID_W-1:0]      filter28_id,
	output logic [CAFPC_ID_W-1:0]      filter29_id,
	output logic                       msg_valid,
	output logic [CAFPC_ID_W-1:0]      msg_id
);
	assign mask0 = '1;
	assign mask1 = 29'h1FFFFF00;
	assign mask2 = 29'h000000FF;
	assign mask3 = '0;
	assign filter28_id = 29'h00000456;
	assign filter29_id = 29'h00000123;
	initial msg_valid = 1'h0;
	initial msg_id = '0;
	task automatic send(input logic [CAFPC_ID_W-1:0] id);
		msg_valid <= 1'h1;
		msg_id <= id;
		@(posedge pclk);
		msg_valid <= 1'h0;
		msg_id <= ~id;
	endtask
endmodule
`default_nettype wire

// *** sim/cafpc_tb.sv ***
// Purpose: Bench for the filter pair control block
// Assumes: Full strobes, transfers start just after a rising edge
// Notes:   Routes expected from the model's masks and filter values
`timescale 1ns/1ps
`default_nettype none
module tb;
	import cafpc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd, exp;
	logic [3:0] pstrb = 4'hF;
	logic [CAFPC_ID_W-1:0] mask0, mask1, mask2, mask3, filter28_id, filter29_id, msg_id;
	logic msg_valid, route_valid, route_filter29, filter29_enable, filter28_enable;
	logic [1:0] filter29_mask_select, filter28_mask_select;
	logic [4:0] route_fifo, filter29_fifo_select, filter28_fifo_select;
	int fails = 0, check_count = 0, c28 = 0, c29 = 0;
	logic [6:0] lst = '0;
	cafpc_top cafpc_top_i (.*);
	cafpc_msg_model cafpc_msg_model_i (.*);
	function automatic logic [28:0] mk(input logic [1:0] s);
		return s[1] ? (s[0] ? mask3 : mask2) : (s[0] ? mask1 : mask0);
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, s);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Answer taken at the rising edge where pready is sampled high
		do @(posedge pclk); while (pready !== 1'h1 && ++n < 50);
		if (n >= 50) fails++;
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// Idle cycle so psel is never assigned twice in one step
		@(posedge pclk);
	endtask
	task automatic route(input logic [28:0] id);
		logic h29, h28;
		h29 = exp[15] && ((id ^ filter29_id) & mk(exp[14:13])) == '0;
		h28 = exp[7] && ((id ^ filter28_id) & mk(exp[6:5])) == '0;
		if (h29) c29++;
		if (h28) c28++;
		if (h29 | h28) lst = {h29, h29 ? exp[12:8] : exp[4:0]};
		cafpc_msg_model_i.send(id);
		@(negedge pclk);
		chk("route_valid", {31'h0, h29 | h28}, {31'h0, route_valid});
		if (h29 | h28)
			chk("route", {26'h0, h29, h29 ? exp[12:8] : exp[4:0]}, {26'h0, route_filter29, route_fifo});
		@(posedge pclk);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial forever #25 pclk = ~pclk;
	initial begin
		repeat (3000) @(posedge pclk);
		fails++;
		test_done;
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		apb(1'h0, CAFPC_ADDR_CTRL7, 32'h0);
		chk("ctrl reset", CAFPC_CTRL_RESET, rd);
		apb(1'h0, 12'h00C, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		for (int m = 0; m < 4; m++) begin
			// Clears both enables so the next write can change the selects
			apb(1'h1, CAFPC_ADDR_CTRL7, {16'h0, 1'h0, 2'(m), 5'(31 - m), 1'h0, 2'(3 - m), 5'(m)});
			exp = {16'h0, 1'h1, 2'(m), 5'(31 - m), 1'h1, 2'(3 - m), 5'(m)};
			apb(1'h1, CAFPC_ADDR_CTRL7, exp);
			apb(1'h0, CAFPC_ADDR_CTRL7, 32'h0);
			chk("ctrl", exp, rd);
			route(29'h00001123);
			route(29'h00000456);
		end
		apb(1'h1, CAFPC_ADDR_CTRL7, 32'h0);
		exp[15] = 1'h0;
		exp[7] = 1'h0;
		apb(1'h0, CAFPC_ADDR_CTRL7, 32'h0);
		chk("ctrl locked", exp, rd);
		route(29'h00000456);
		apb(1'h0, CAFPC_ADDR_STATUS, 32'h0);
		chk("status", {25'h0, lst, 1'h0}, rd);
		apb(1'h0, CAFPC_ADDR_MATCH, 32'h0);
		chk("hits", {16'h0, 8'(c29), 8'(c28)}, rd);
		apb(1'h1, CAFPC_ADDR_MATCH, 32'h0);
		apb(1'h0, CAFPC_ADDR_MATCH, 32'h0);
		chk("hits clear", 32'h0, rd);
		test_done;
	end
endmodule
`default_nettype wire
